// >>> rtl/admc_pkg.sv
package admc_pkg;
  localparam logic [9:0] ADDR_MODE_CTRL = 10'h100;
  localparam logic [9:0] ADDR_CLK_SEL = 10'h101;
  localparam int CMD_BITS = 16;
  localparam int DATA_BITS_MODE = 16;
  localparam int DATA_BITS_CLK = 16;
  localparam int RD_BYTE_BITS = 8;
  // Mode register fields
  localparam int WL_LSB = 0;
  localparam int FMT_LSB = 2;
  localparam int DEEMP_LSB = 4;
  localparam int PWRDN_BIT = 6;
  localparam int MUTE_BIT = 7;
  localparam int CAPOUT_BIT = 8;
  localparam int SAFE_BIT = 9;
  localparam int HALT_BIT = 10;
  localparam int AUX_BIT = 11;
  localparam logic [11:0] MODE_RESET = 12'h000;
  // Clock register fields
  localparam int MCO_LSB = 0;
  localparam int MCI_FREQ_BIT = 2;
  localparam int RSVD_BIT = 3;
  localparam int MCSRC_LSB = 4;
  localparam int SISRC_LSB = 6;
  localparam int SOUT_BIT = 8;
  localparam int RAMP_BIT = 9;
  localparam logic [9:0] CLK_RESET = 10'h000;
  localparam logic [1:0] SEL_UNUSED = 2'h3;
  // Ramp lengths in frame periods, then the safeload slot count
  localparam int RAMP_FAST_FRAMES = 1024;
  localparam int RAMP_SLOW_FRAMES = 8192;
  localparam int MUTE_FRAMES = 512;
  localparam int SAFE_SLOTS = 5;

  typedef enum logic [1:0] {ADMC_FMT_I2S, ADMC_FMT_RJ, ADMC_FMT_DSP, ADMC_FMT_LJ} admc_fmt_t;
  typedef enum logic [1:0] {ADMC_DE_NONE, ADMC_DE_44K1, ADMC_DE_32K, ADMC_DE_48K} admc_deemp_t;
  typedef enum logic [1:0] {ADMC_MCO_OFF, ADMC_MCO_CORE, ADMC_MCO_HALF, ADMC_MCO_THRU} admc_mco_t;

  typedef struct packed {
    admc_fmt_t fmt;
    logic [4:0] word_bits;
    admc_deemp_t deemp;
    logic aux_in_sel;
    logic core_clk_gate;
    logic capture_out_en;
  } admc_mode_t;

  typedef struct packed {
    admc_mco_t mco_mode;
    logic mclk_doubler_en;
    logic [1:0] mclk_src;
    logic [1:0] serial_src;
    logic serial_out_en;
    logic slow_ramp;
  } admc_clk_t;
endpackage

// >>> rtl/admc_ramp.sv
`timescale 1ns/1ps
module admc_ramp #(
  parameter int GAIN_BITS = 14
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic frame_tick,
  input wire logic mute_req,
  input wire logic slow_ramp,
  output logic [GAIN_BITS-1:0] gain,
  output logic silent
);
  initial begin
    if (GAIN_BITS < 14) begin
      $error("GAIN_BITS too small");
    end
  end
  // Unity gain is half of full scale, so a mute from unity takes half the full-scale ramp
  localparam int UNITY = admc_pkg::RAMP_SLOW_FRAMES;
  localparam logic [GAIN_BITS-1:0] FULL = GAIN_BITS'(UNITY);
  localparam logic [GAIN_BITS-1:0] STEP_FAST = GAIN_BITS'(2 * UNITY / admc_pkg::RAMP_FAST_FRAMES);
  localparam logic [GAIN_BITS-1:0] STEP_SLOW = GAIN_BITS'(2 * UNITY / admc_pkg::RAMP_SLOW_FRAMES);
  logic [GAIN_BITS-1:0] step;

  assign step = slow_ramp ? STEP_SLOW : STEP_FAST;

  // Linear ramp: one step per frame toward the target
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gain <= FULL;
    end else if (frame_tick) begin
      if (mute_req) begin
        gain <= (gain > step) ? gain - step : '0;
      end else begin
        gain <= (FULL - gain > step) ? gain + step : FULL;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      silent <= 1'b0;
    end else begin
      silent <= mute_req && (gain == '0);
    end
  end
endmodule

// >>> rtl/admc_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Word length code 00=24, 01=20, 1x=16 bits; sets right-justified MSB position.
// - Format bits 3:2 pick I2S, right-justified, DSP or left-justified input.
// - De-emphasis bits 5:4 pick none, 44.1, 32 or 48 kHz curve.
// - Bit 6 gates core clocks without reset; only reset pin resets.
// - Bit 7 ramps volume down; clearing ramps it back up.
// - Bit 8 enables capture serial output pin; host sets it before reading.
// - Writing 1 to bit 9 transfers only safeload slots written since last transfer.
// - Status bit 0 sets when transfer done, clears after the read returning it.
// - Bit 10 ramps volume down then shuts the core down.
// - Status bit 1 sets once core shutdown completes.
// - Bit 11 makes shared pin an aux serial input, else 44.1 kHz de-emphasis enable.
// - Clock-out bits 1:0: off, core clock, core clock halved, input feedthrough.
// - Halved output is inverted versus the input clock; feedthrough is not.
// - Bit 2 selects 512x direct input or 256x input with doubler.
// - Bits 5:4 select one of three master clock inputs; 11 unused.
// - Bits 7:6 select one of three serial input groups; 11 unused.
// - Second register bit 8 enables three serial outputs; resets disabled.
// - Bit 9 selects 1024 or 8192 frame full ramp.
// - Transaction: 00000, read flag, address 9:8, address 7:0, then data bytes.
// - Latch low frames a transaction; data sampled on control clock rising edge.
module admc_regs #(
  parameter int GAIN_BITS = 14
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic control_latch,
  input wire logic control_clock,
  input wire logic control_data_in,
  output logic control_data_out,
  output logic control_data_out_oe_n,
  input wire logic frame_clock,
  input wire logic deemp_aux_pin,
  input wire logic [2:0] master_clock_src,
  input wire logic [2:0] serial_audio_data_src,
  input wire logic [2:0] frame_clock_src,
  input wire logic [2:0] bit_clock_src,
  input wire logic [4:0] safeload_written,
  input wire logic safeload_slot_done,
  output logic [4:0] safeload_copy_mask,
  output logic safeload_go,
  output admc_pkg::admc_mode_t mode_cfg,
  output admc_pkg::admc_clk_t clk_cfg,
  output logic aux_serial_data,
  output logic core_clk_enable,
  output logic core_halted,
  output logic [GAIN_BITS-1:0] volume_gain,
  output logic capture_serial_out_pin_en,
  output logic [2:0] serial_out_pins,
  output logic serial_out_oe_n,
  output logic master_clock_output_pin,
  output logic master_clock_output_oe_n
);
  initial begin
    if (GAIN_BITS < 14) begin
      $error("GAIN_BITS too small");
    end
  end

  typedef enum {ADMC_IDLE, ADMC_SHIFT, ADMC_READ, ADMC_IGNORE} admc_spi_t;
  admc_spi_t spi_reg;
  logic [11:0] mode_reg;
  logic [9:0] clk_reg;
  logic [4:0] bit_cnt_reg;
  localparam int CMD_W = admc_pkg::CMD_BITS;
  logic [CMD_W-1:0] cmd_reg;
  logic [15:0] data_reg;
  logic [5:0] data_cnt_reg;
  logic control_clock_d_reg;
  logic frame_d_reg;
  logic safe_done_reg;
  logic safe_busy_reg;
  logic [4:0] safe_pend_reg;
  logic halt_done_reg;
  logic read_stat_reg;
  logic [1:0] rd_shift_reg;
  logic half_clk_reg;
  logic mclk_in;
  logic control_clock_rise;
  logic frame_tick;
  logic ramp_silent;
  logic mute_req;

  assign control_clock_rise = control_clock && !control_clock_d_reg;
  assign frame_tick = frame_clock && !frame_d_reg;
  assign mute_req = mode_reg[admc_pkg::MUTE_BIT] || mode_reg[admc_pkg::HALT_BIT];
  assign mclk_in = master_clock_src[clk_reg[admc_pkg::MCSRC_LSB +: 2]];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      control_clock_d_reg <= 1'b0;
      frame_d_reg <= 1'b0;
    end else begin
      control_clock_d_reg <= control_clock;
      frame_d_reg <= frame_clock;
    end
  end

  // Serial control port: command word, then data bits MSB first
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      spi_reg <= ADMC_IDLE;
      bit_cnt_reg <= '0;
      cmd_reg <= '0;
      data_reg <= '0;
      data_cnt_reg <= '0;
    end else if (control_latch) begin
      spi_reg <= ADMC_IDLE;
      bit_cnt_reg <= '0;
      data_cnt_reg <= '0;
    end else if (control_clock_rise) begin
      case (spi_reg)
        ADMC_IDLE, ADMC_SHIFT: begin
          if (bit_cnt_reg < 5'(CMD_W)) begin
            cmd_reg <= {cmd_reg[CMD_W-2:0], control_data_in};
            bit_cnt_reg <= bit_cnt_reg + 5'h1;
            spi_reg <= ADMC_SHIFT;
          end else if (cmd_reg[15:11] != 5'h00) begin
            spi_reg <= ADMC_IGNORE;
          end else if (cmd_reg[10]) begin
            spi_reg <= ADMC_READ;
          end else begin
            data_reg <= {data_reg[14:0], control_data_in};
            data_cnt_reg <= data_cnt_reg + 6'h1;
          end
        end
        ADMC_READ: begin
          data_cnt_reg <= data_cnt_reg + 6'h1;
        end
        ADMC_IGNORE: begin
          spi_reg <= ADMC_IGNORE;
        end
        default: begin
          spi_reg <= ADMC_IDLE;
        end
      endcase
    end
  end

  logic wr_commit;
  logic [9:0] cmd_addr;
  assign cmd_addr = cmd_reg[9:0];
  assign wr_commit = (spi_reg == ADMC_SHIFT) && !cmd_reg[10] && (cmd_reg[15:11] == 5'h00)
                     && (data_cnt_reg == 6'd16) && !control_clock_rise;
  logic wr_seen_reg;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_seen_reg <= 1'b0;
    end else if (control_latch || (data_cnt_reg != 6'd16)) begin
      wr_seen_reg <= 1'b0;
    end else if (wr_commit) begin
      wr_seen_reg <= 1'b1;
    end
  end

  logic wr_pulse;
  assign wr_pulse = wr_commit && !wr_seen_reg;

  // First control register; safeload request bit is a self-clearing strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= admc_pkg::MODE_RESET;
    end else if (wr_pulse && cmd_addr == admc_pkg::ADDR_MODE_CTRL) begin
      mode_reg <= data_reg[11:0];
    end else begin
      mode_reg[admc_pkg::SAFE_BIT] <= 1'b0;
    end
  end

  // Second control register; reserved bit is written as zero, unused codes are held
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_reg <= admc_pkg::CLK_RESET;
    end else if (wr_pulse && cmd_addr == admc_pkg::ADDR_CLK_SEL) begin
      clk_reg[1:0] <= data_reg[1:0];
      clk_reg[admc_pkg::MCI_FREQ_BIT] <= data_reg[admc_pkg::MCI_FREQ_BIT];
      clk_reg[admc_pkg::RSVD_BIT] <= 1'b0;
      if (data_reg[5:4] != admc_pkg::SEL_UNUSED) begin
        clk_reg[5:4] <= data_reg[5:4];
      end
      if (data_reg[7:6] != admc_pkg::SEL_UNUSED) begin
        clk_reg[7:6] <= data_reg[7:6];
      end
      clk_reg[9:8] <= data_reg[9:8];
    end
  end

  // Safeload transfer: latch written slots at request, wait for copy engine
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      safe_busy_reg <= 1'b0;
      safe_pend_reg <= '0;
      safeload_go <= 1'b0;
      safeload_copy_mask <= '0;
    end else begin
      safeload_go <= 1'b0;
      if (!safe_busy_reg && mode_reg[admc_pkg::SAFE_BIT]) begin
        safe_busy_reg <= 1'b1;
        safe_pend_reg <= safeload_written;
        safeload_copy_mask <= safeload_written;
        safeload_go <= 1'b1;
      end else if (safe_busy_reg && (safe_pend_reg == '0 || safeload_slot_done)) begin
        safe_busy_reg <= 1'b0;
        safe_pend_reg <= '0;
      end
    end
  end

  // Read status: done flag clears after the read that returned it, set wins
  logic safe_done_set;
  assign safe_done_set = safe_busy_reg && (safe_pend_reg == '0 || safeload_slot_done);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      safe_done_reg <= 1'b0;
      read_stat_reg <= 1'b0;
    end else begin
      if (spi_reg == ADMC_READ && cmd_addr == admc_pkg::ADDR_MODE_CTRL) begin
        read_stat_reg <= 1'b1;
      end else if (control_latch) begin
        read_stat_reg <= 1'b0;
      end
      if (safe_done_set) begin
        safe_done_reg <= 1'b1;
      end else if (control_latch && read_stat_reg && rd_shift_reg[0]) begin
        safe_done_reg <= 1'b0;
      end
    end
  end

  // Halt: after ramp reaches silence the core stops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      halt_done_reg <= 1'b0;
    end else if (!mode_reg[admc_pkg::HALT_BIT]) begin
      halt_done_reg <= 1'b0;
    end else if (ramp_silent) begin
      halt_done_reg <= 1'b1;
    end
  end

  // Readback: 16-bit word, status in the low two bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      control_data_out <= 1'b0;
      control_data_out_oe_n <= 1'b1;
      rd_shift_reg <= '0;
    end else if (spi_reg == ADMC_READ && cmd_addr == admc_pkg::ADDR_MODE_CTRL) begin
      control_data_out_oe_n <= 1'b0;
      if (data_cnt_reg == 6'd0) begin
        rd_shift_reg <= {halt_done_reg, safe_done_reg};
      end
      if (data_cnt_reg >= 6'd14 && data_cnt_reg < 6'd16) begin
        control_data_out <= (data_cnt_reg == 6'd14) ? rd_shift_reg[1] : rd_shift_reg[0];
      end else begin
        control_data_out <= 1'b0;
      end
    end else begin
      control_data_out <= 1'b0;
      control_data_out_oe_n <= 1'b1;
      if (control_latch && !read_stat_reg) begin
        rd_shift_reg <= '0;
      end
    end
  end

  // Decoded configuration outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_cfg <= '0;
      clk_cfg <= '0;
    end else begin
      mode_cfg.fmt <= admc_pkg::admc_fmt_t'(mode_reg[admc_pkg::FMT_LSB +: 2]);
      case (mode_reg[admc_pkg::WL_LSB +: 2])
        2'h0: mode_cfg.word_bits <= 5'd24;
        2'h1: mode_cfg.word_bits <= 5'd20;
        default: mode_cfg.word_bits <= 5'd16;
      endcase
      if (!mode_reg[admc_pkg::AUX_BIT] && deemp_aux_pin) begin
        mode_cfg.deemp <= admc_pkg::ADMC_DE_44K1;
      end else begin
        mode_cfg.deemp <= admc_pkg::admc_deemp_t'(mode_reg[admc_pkg::DEEMP_LSB +: 2]);
      end
      mode_cfg.aux_in_sel <= mode_reg[admc_pkg::AUX_BIT];
      mode_cfg.core_clk_gate <= mode_reg[admc_pkg::PWRDN_BIT];
      mode_cfg.capture_out_en <= mode_reg[admc_pkg::CAPOUT_BIT];
      clk_cfg.mco_mode <= admc_pkg::admc_mco_t'(clk_reg[admc_pkg::MCO_LSB +: 2]);
      clk_cfg.mclk_doubler_en <= clk_reg[admc_pkg::MCI_FREQ_BIT];
      clk_cfg.mclk_src <= clk_reg[5:4];
      clk_cfg.serial_src <= clk_reg[7:6];
      clk_cfg.serial_out_en <= clk_reg[admc_pkg::SOUT_BIT];
      clk_cfg.slow_ramp <= clk_reg[admc_pkg::RAMP_BIT];
    end
  end

  // Pin-side outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aux_serial_data <= 1'b0;
      core_clk_enable <= 1'b1;
      core_halted <= 1'b0;
      capture_serial_out_pin_en <= 1'b0;
      serial_out_pins <= '0;
      serial_out_oe_n <= 1'b1;
    end else begin
      aux_serial_data <= mode_reg[admc_pkg::AUX_BIT] && deemp_aux_pin;
      core_clk_enable <= !mode_reg[admc_pkg::PWRDN_BIT] && !halt_done_reg;
      core_halted <= halt_done_reg;
      capture_serial_out_pin_en <= mode_reg[admc_pkg::CAPOUT_BIT];
      serial_out_pins <= {serial_audio_data_src[clk_reg[7:6]], frame_clock_src[clk_reg[7:6]],
                          bit_clock_src[clk_reg[7:6]]};
      serial_out_oe_n <= !clk_reg[admc_pkg::SOUT_BIT];
    end
  end

  // Master clock output; halved clock toggles so it starts inverted to input
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      half_clk_reg <= 1'b0;
      master_clock_output_pin <= 1'b0;
      master_clock_output_oe_n <= 1'b1;
    end else begin
      half_clk_reg <= !half_clk_reg;
      master_clock_output_oe_n <= (clk_reg[1:0] == 2'h0);
      case (admc_pkg::admc_mco_t'(clk_reg[1:0]))
        admc_pkg::ADMC_MCO_CORE: master_clock_output_pin <= core_clk_enable;
        admc_pkg::ADMC_MCO_HALF: master_clock_output_pin <= !half_clk_reg;
        admc_pkg::ADMC_MCO_THRU: master_clock_output_pin <= mclk_in;
        default: master_clock_output_pin <= 1'b0;
      endcase
    end
  end

  admc_ramp #(
    .GAIN_BITS(GAIN_BITS)
  ) u_ramp (
    .core_clk(core_clk),
    .reset(reset),
    .frame_tick(frame_tick),
    .mute_req(mute_req),
    .slow_ramp(clk_reg[admc_pkg::RAMP_BIT]),
    .gain(volume_gain),
    .silent(ramp_silent)
  );
endmodule

// >>> bench/admc_regs_monitor.sv
`timescale 1ns/1ps
module admc_regs_monitor #(
  parameter int GAIN_BITS = 14
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic control_latch,
  input wire logic control_data_out_oe_n,
  input wire logic deemp_aux_pin,
  input wire logic [2:0] master_clock_src,
  input wire logic [2:0] serial_audio_data_src,
  input wire logic [2:0] frame_clock_src,
  input wire logic [2:0] bit_clock_src,
  input wire logic [4:0] safeload_written,
  input wire logic [4:0] safeload_copy_mask,
  input wire logic safeload_go,
  input wire admc_pkg::admc_mode_t mode_cfg,
  input wire admc_pkg::admc_clk_t clk_cfg,
  input wire logic aux_serial_data,
  input wire logic core_clk_enable,
  input wire logic core_halted,
  input wire logic [GAIN_BITS-1:0] volume_gain,
  input wire logic [2:0] serial_out_pins,
  input wire logic serial_out_oe_n,
  input wire logic master_clock_output_pin,
  input wire logic master_clock_output_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_out_released: assert property (control_latch [*3] |-> control_data_out_oe_n)
    else $error("readback driven while idle");
  a_mco_off: assert property (clk_cfg.mco_mode == admc_pkg::ADMC_MCO_OFF [*2] |-> master_clock_output_oe_n)
    else $error("clock output driven while off");
  a_mco_half: assert property (clk_cfg.mco_mode == admc_pkg::ADMC_MCO_HALF [*3]
    |-> !master_clock_output_oe_n && master_clock_output_pin != $past(master_clock_output_pin))
    else $error("halved clock output does not toggle");
  a_mco_thru: assert property ((clk_cfg.mco_mode == admc_pkg::ADMC_MCO_THRU && $stable(master_clock_src)) [*3]
    |-> !master_clock_output_oe_n && master_clock_output_pin == master_clock_src[clk_cfg.mclk_src])
    else $error("feedthrough clock wrong");
  a_sout_off: assert property (!clk_cfg.serial_out_en [*2] |-> serial_out_oe_n)
    else $error("serial outputs driven while off");
  a_sout_mux: assert property ((clk_cfg.serial_out_en && $stable(serial_audio_data_src) && $stable(frame_clock_src)
    && $stable(bit_clock_src)) [*3] |-> !serial_out_oe_n && serial_out_pins == {serial_audio_data_src[clk_cfg.serial_src],
    frame_clock_src[clk_cfg.serial_src], bit_clock_src[clk_cfg.serial_src]})
    else $error("serial outputs do not follow mux");
  a_ramp_step: assert property (volume_gain != $past(volume_gain) |->
    (volume_gain > $past(volume_gain) ? volume_gain - $past(volume_gain) : $past(volume_gain) - volume_gain)
    <= (clk_cfg.slow_ramp ? 2 : 16))
    else $error("volume step too large");
  a_halt_silent: assert property (core_halted |-> volume_gain == 0)
    else $error("core halted before silence");
  a_safe_mask: assert property (safeload_go |-> safeload_copy_mask == safeload_written)
    else $error("copy mask differs from written slots");
  a_go_pulse: assert property (safeload_go |=> !safeload_go)
    else $error("transfer start longer than one cycle");
  a_aux_follow: assert property ((mode_cfg.aux_in_sel && $stable(deemp_aux_pin)) [*3]
    |-> aux_serial_data == deemp_aux_pin)
    else $error("aux data does not follow pin");
  a_gate_clk: assert property (mode_cfg.core_clk_gate [*2] |-> !core_clk_enable)
    else $error("core clock runs while powered down");
  a_sel_legal: assert property (clk_cfg.mclk_src != admc_pkg::SEL_UNUSED && clk_cfg.serial_src != admc_pkg::SEL_UNUSED)
    else $error("unused mux code taken");
  c_halted: cover property (core_halted);
  c_safe_go: cover property (safeload_go);
  c_thru: cover property (clk_cfg.mco_mode == admc_pkg::ADMC_MCO_THRU && !master_clock_output_oe_n);
endmodule
bind admc_regs admc_regs_monitor #(.GAIN_BITS(GAIN_BITS)) admc_regs_monitor_i (.*);

// >>> bench/admc_host.sv
`timescale 1ns/1ps
module admc_host (
  input wire logic core_clk,
  input wire logic control_data_out,
  input wire logic control_data_out_oe_n,
  output logic control_latch,
  output logic control_clock,
  output logic control_data_in,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  int half = 2;
  logic last_bit = 1'b0;
  logic line;
  // A released readback line floats: show the inverse of its last driven level
  assign line = control_data_out_oe_n ? ~last_bit : control_data_out;
  always @(posedge core_clk) if (!control_data_out_oe_n) last_bit <= control_data_out;
  initial begin
    control_latch = 1'b1;
    control_clock = 1'b0;
    control_data_in = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  task automatic xfer(input logic rd, input logic [4:0] pre, input logic [9:0] addr, input logic [15:0] wdata);
    logic [31:0] sh;
    logic [15:0] got;
    sh = {pre, rd, addr, wdata};
    got = 16'h0000;
    @(posedge core_clk) control_latch <= 1'b0;
    for (int i = 0; i < 33; i++) begin
      @(posedge core_clk) control_clock <= 1'b0;
      control_data_in <= (i < 32) ? sh[31-i] : 1'b0;
      repeat (half) @(posedge core_clk);
      if (i >= 17) got = {got[14:0], line};
      control_clock <= 1'b1;
      repeat (half) @(posedge core_clk);
    end
    control_clock <= 1'b0;
    repeat (half) @(posedge core_clk);
    control_latch <= 1'b1;
    rd_data <= got;
    rd_valid <= rd;
    @(posedge core_clk) rd_valid <= 1'b0;
  endtask
endmodule

// >>> bench/test_audio_dsp_mode_control_regs.sv
`timescale 1ns/1ps
module test_audio_dsp_mode_control_regs;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic control_latch, control_clock, control_data_in, control_data_out, control_data_out_oe_n;
  logic frame_clock = 1'b0;
  logic deemp_aux_pin = 1'b0;
  // Pin level the design took at the previous edge
  logic pin_d = 1'b0;
  logic safeload_slot_done = 1'b0;
  logic [2:0] master_clock_src = 3'h0, serial_audio_data_src = 3'h0, frame_clock_src = 3'h0, bit_clock_src = 3'h0;
  logic [4:0] safeload_written = 5'h00, safeload_copy_mask, go_mask = 5'h00;
  logic safeload_go, aux_serial_data, core_clk_enable, core_halted, capture_serial_out_pin_en, serial_out_oe_n;
  logic master_clock_output_pin, master_clock_output_oe_n, rd_valid;
  logic [2:0] serial_out_pins, tick = 3'h0;
  logic [13:0] volume_gain;
  logic [15:0] rd_data, d;
  admc_pkg::admc_mode_t mode_cfg;
  admc_pkg::admc_clk_t clk_cfg;
  logic [1:0] exp_q[$];
  integer seed = 32'h074d;
  int error_cnt = 0, num_checks = 0, n;
  admc_regs admc_regs_i (.*);
  admc_host admc_host_i (.*);
  initial forever #4 core_clk = ~core_clk;
  // Source pins change every eight cycles so the mux outputs can settle
  always @(posedge core_clk) begin
    tick <= tick + 3'h1;
    if (tick == 3'h0) {deemp_aux_pin, master_clock_src, serial_audio_data_src, frame_clock_src, bit_clock_src} <= 13'($random(seed));
    if (safeload_go === 1'b1) go_mask <= safeload_copy_mask;
    pin_d <= deemp_aux_pin;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge core_clk) if (rd_valid === 1'b1 && exp_q.size() > 0) check("status", {14'h0, exp_q.pop_front()}, {14'h0, rd_data[1:0]});
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    admc_host_i.xfer(1'b0, 5'h00, a, v);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rd(input logic [1:0] e);
    exp_q.push_back(e);
    admc_host_i.xfer(1'b1, 5'h00, admc_pkg::ADDR_MODE_CTRL, 16'h0000);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic frames(input int k);
    repeat (k) begin
      @(posedge core_clk) frame_clock <= 1'b1;
      repeat (2) @(posedge core_clk);
      frame_clock <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task automatic chk_clk(input logic [15:0] v);
    check("clk_cfg", 16'({v[1:0], v[2], v[5:4], v[7:6], v[8], v[9]}), 16'(clk_cfg));
  endtask
  initial begin
    #200us;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("gain", 16'd8192, 16'(volume_gain));
    check("oe", 16'h0003, 16'({serial_out_oe_n, master_clock_output_oe_n}));
    for (int c = 0; c < 4; c++) begin
      wr(admc_pkg::ADDR_MODE_CTRL, 16'(c * 21) | (c[0] ? 16'h0940 : 16'h0000));
      n = c == 0 ? 24 : c == 1 ? 20 : 16;
      check("mode_cfg", 16'({2'(c), 5'(n), ((!c[0] && pin_d) ? 2'h1 : 2'(c)), {3{c[0]}}}), 16'(mode_cfg));
      check("pins", 16'({~c[0], c[0]}), 16'({core_clk_enable, capture_serial_out_pin_en}));
    end
    wr(admc_pkg::ADDR_MODE_CTRL, 16'h0800);
    for (int c = 0; c < 4; c++) begin
      d = 16'($random(seed)) & 16'h0204;
      d[1:0] = 2'(c);
      d[8] = c[0];
      d[5:4] = 2'(c % 3);
      d[7:6] = 2'((c + 1) % 3);
      admc_host_i.half = 2 + c * 2;
      wr(admc_pkg::ADDR_CLK_SEL, d);
      chk_clk(d);
      wr(admc_pkg::ADDR_CLK_SEL, d | 16'h00f8);
      chk_clk(d);
    end
    admc_host_i.xfer(1'b0, 5'h10, admc_pkg::ADDR_CLK_SEL, ~d);
    chk_clk(d);
    wr(10'h102, ~d);
    chk_clk(d);
    admc_host_i.half = 2;
    safeload_written <= 5'($random(seed)) | 5'h01;
    wr(admc_pkg::ADDR_MODE_CTRL, 16'h0200);
    check("copy_mask", 16'(safeload_written), 16'(go_mask));
    @(posedge core_clk) safeload_slot_done <= 1'b1;
    @(posedge core_clk) safeload_slot_done <= 1'b0;
    safeload_written <= 5'h00;
    repeat (4) @(posedge core_clk);
    rd(2'b01);
    rd(2'b00);
    for (int s = 0; s < 2; s++) begin
      wr(admc_pkg::ADDR_CLK_SEL, s == 1 ? 16'h0200 : 16'h0000);
      wr(admc_pkg::ADDR_MODE_CTRL, 16'h0080);
      frames(3);
      check("gain_down", 16'(8192 - 3 * (s == 1 ? 2 : 16)), 16'(volume_gain));
      wr(admc_pkg::ADDR_MODE_CTRL, 16'h0000);
      frames(3);
      check("gain_up", 16'd8192, 16'(volume_gain));
    end
    wr(admc_pkg::ADDR_CLK_SEL, 16'h0000);
    wr(admc_pkg::ADDR_MODE_CTRL, 16'h0400);
    for (n = 0; n < 1100 && core_halted !== 1'b1; n++) begin
      frames(1);
      @(negedge core_clk);
    end
    check("halt_frames", 16'(admc_pkg::MUTE_FRAMES), 16'(n));
    rd(2'b10);
    wr(admc_pkg::ADDR_MODE_CTRL, 16'h0000);
    frames(4);
    check("gain_restart", 16'd64, 16'(volume_gain));
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("reset_state", 16'h2000, 16'({core_halted, core_clk_enable, volume_gain[12:0]}));
    finish_test();
  end
endmodule
